// File: core/accum_consts.svh
// Constants for the metering mode configuration bank.
// Assumes inclusion by the package and the design modules of this bank.
`ifndef ACCUM_CONSTS_SVH
`define ACCUM_CONSTS_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define PWR_W 24
`define N_PHASE 3
`define N_TERM 6
`define ADDR_W 18
`define DATA_W 32
`define IDX_W 16
`define REG_W 8

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define MEAS_MODE_IDX 16'hE700
`define ACC_MODE_IDX 16'hE701
`define STAT_ZERO_IDX 16'hE600

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MEAS_MODE_RST 8'h1C
`define ACC_MODE_RST 8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ACT_REV_SEL_BIT 0
`define REACT_REV_SEL_BIT 1
`define PEAK_LSB 2
`define PEAK_MSB 4
`define ACT_ACC_LSB 0
`define ACT_ACC_MSB 1
`define REACT_ACC_LSB 2
`define REACT_ACC_MSB 3
`define ST_ACT_REV_LSB 6
`define ST_REACT_REV_LSB 10

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: core/accum_pkg.sv
// Types shared by the accumulation mode bank and its term conditioner.
// Assumes the constants header sits in the same include path.
`include "accum_consts.svh"

package accum_pkg;

  typedef logic signed [`PWR_W-1:0] power_t;

  typedef enum logic [1:0] {
    ACT_SIGNED = 2'h0,
    ACT_POS_ONLY = 2'h1,
    ACT_RSVD = 2'h2,
    ACT_ABS = 2'h3
  } act_mode_t;

  typedef enum logic [1:0] {
    REACT_SIGNED = 2'h0,
    REACT_RSVD = 2'h1,
    REACT_BY_ACT = 2'h2,
    REACT_ABS = 2'h3
  } react_mode_t;

endpackage : accum_pkg

// File: core/energy_accum_mode_config.sv
// Measurement and accumulation mode registers with reversal flags and
// shaping of the per-phase power terms fed to energy and pulse paths.
// Assumes power terms arrive from logic on clk_i with a one-cycle strobe,
// and an AXI4-Lite master for the registers.
//
// Notes on behaviour
// - active reversal flags follow total active power when the source bit is 0, fundamental when 1.
// - phase A, B, C active reversal is reported at status bits 6, 7 and 8.
// - reactive reversal flags follow total reactive power when the source bit is 0, fundamental when 1.
// - phase A, B, C reactive reversal is reported at status bits 10, 11 and 12.
// - measurement mode bits 2, 3, 4 include phase A, B, C in peak detection, each resetting to 1.
// - measurement mode bits 7 to 5 do nothing and reset to zero.
// - active mode 00 accumulates active power signed in energy and pulse paths.
// - active mode 01 keeps only positive power for energy but stays signed for pulses.
// - active mode 10 behaves exactly as 00.
// - active mode 11 accumulates absolute active power in both paths.
// - accumulation mode bits 3 to 2 steer reactive accumulation using active and reactive power.
// - reactive mode 10 adds reactive power as is for positive active power, negated for negative.
// - reactive mode 11 accumulates absolute reactive power; 00 and 01 are signed.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "accum_consts.svh"

module energy_accum_mode_config import accum_pkg::*; (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // axi4-lite write address
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [`ADDR_W-1:0] s_axi_awaddr_i,
  // axi4-lite write data
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [`DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  // axi4-lite write response
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // axi4-lite read address
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [`ADDR_W-1:0] s_axi_araddr_i,
  // axi4-lite read data
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [`DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // power terms in, index 2*phase+kind, kind 0 total, 1 fundamental
  input wire logic pwr_upd_i,
  input wire logic [`N_TERM-1:0][`PWR_W-1:0] act_pwr_i,
  input wire logic [`N_TERM-1:0][`PWR_W-1:0] react_pwr_i,
  // shaped terms out, same indexing
  output logic terms_valid_o,
  output logic [`N_TERM-1:0][`PWR_W-1:0] act_energy_o,
  output logic [`N_TERM-1:0][`PWR_W-1:0] act_pulse_o,
  output logic [`N_TERM-1:0][`PWR_W-1:0] react_energy_o,
  output logic [`N_TERM-1:0][`PWR_W-1:0] react_pulse_o,
  // status and peak selection
  output logic [`N_PHASE-1:0] active_reversed_o,
  output logic [`N_PHASE-1:0] reactive_reversed_o,
  output logic [`N_PHASE-1:0] peak_phase_include_o
);

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  function automatic logic reg_hit(input logic [`ADDR_W-1:0] a,
                                   input logic [`IDX_W-1:0] idx);
    reg_hit = (a == {idx, 2'h0});
  endfunction : reg_hit

  function automatic logic is_mapped(input logic [`ADDR_W-1:0] a);
    is_mapped = reg_hit(a, `MEAS_MODE_IDX) || reg_hit(a, `ACC_MODE_IDX) ||
                reg_hit(a, `STAT_ZERO_IDX);
  endfunction : is_mapped

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic active_reversal_source_sel;
  logic reactive_reversal_source_sel;
  logic [`N_PHASE-1:0] peak_phase_include;
  logic [1:0] active_accum_mode;
  logic [1:0] reactive_accum_mode;
  logic [`N_PHASE-1:0] phase_active_reversed_flag;
  logic [`N_PHASE-1:0] phase_reactive_reversed_flag;

  logic aw_have;
  logic w_have;
  logic [`ADDR_W-1:0] wr_addr;
  logic [`REG_W*2-1:0] wr_data;
  logic [1:0] wr_strb;
  logic do_write;
  logic [`N_PHASE-1:0] clr_act;
  logic [`N_PHASE-1:0] clr_react;

  // named reset words, so single fields can be picked out of them
  localparam logic [`REG_W-1:0] meas_rst = `MEAS_MODE_RST;
  localparam logic [`REG_W-1:0] acc_rst = `ACC_MODE_RST;

  assign do_write = aw_have && w_have && !s_axi_bvalid_o;

  // ----------------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_have <= 1'b1;
        wr_addr <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_have <= 1'b1;
        wr_data <= s_axi_wdata_i[`REG_W*2-1:0];
        wr_strb <= s_axi_wstrb_i[1:0];
        s_axi_wready_o <= 1'b0;
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= is_mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // mode registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      active_reversal_source_sel <= meas_rst[`ACT_REV_SEL_BIT];
      reactive_reversal_source_sel <= meas_rst[`REACT_REV_SEL_BIT];
      peak_phase_include <= meas_rst[`PEAK_MSB:`PEAK_LSB];
      active_accum_mode <= acc_rst[`ACT_ACC_MSB:`ACT_ACC_LSB];
      reactive_accum_mode <= acc_rst[`REACT_ACC_MSB:`REACT_ACC_LSB];
    end else if (ce_i && do_write && wr_strb[0]) begin
      // upper measurement bits are not stored and read back as zero
      if (reg_hit(wr_addr, `MEAS_MODE_IDX)) begin
        active_reversal_source_sel <= wr_data[`ACT_REV_SEL_BIT];
        reactive_reversal_source_sel <= wr_data[`REACT_REV_SEL_BIT];
        peak_phase_include <= wr_data[`PEAK_MSB:`PEAK_LSB];
      end
      if (reg_hit(wr_addr, `ACC_MODE_IDX)) begin
        active_accum_mode <= wr_data[`ACT_ACC_MSB:`ACT_ACC_LSB];
        reactive_accum_mode <= wr_data[`REACT_ACC_MSB:`REACT_ACC_LSB];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      peak_phase_include_o <= meas_rst[`PEAK_MSB:`PEAK_LSB];
    end else if (ce_i) begin
      peak_phase_include_o <= peak_phase_include;
    end
  end

  // ----------------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= `RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= '0;
        s_axi_rresp_o <= is_mapped(s_axi_araddr_i) ? `RESP_OKAY : `RESP_SLVERR;
        if (reg_hit(s_axi_araddr_i, `MEAS_MODE_IDX)) begin
          s_axi_rdata_o[`ACT_REV_SEL_BIT] <= active_reversal_source_sel;
          s_axi_rdata_o[`REACT_REV_SEL_BIT] <= reactive_reversal_source_sel;
          s_axi_rdata_o[`PEAK_MSB:`PEAK_LSB] <= peak_phase_include;
        end
        if (reg_hit(s_axi_araddr_i, `ACC_MODE_IDX)) begin
          s_axi_rdata_o[`ACT_ACC_MSB:`ACT_ACC_LSB] <= active_accum_mode;
          s_axi_rdata_o[`REACT_ACC_MSB:`REACT_ACC_LSB] <= reactive_accum_mode;
        end
        if (reg_hit(s_axi_araddr_i, `STAT_ZERO_IDX)) begin
          s_axi_rdata_o[`ST_ACT_REV_LSB+:`N_PHASE] <= phase_active_reversed_flag;
          s_axi_rdata_o[`ST_REACT_REV_LSB+:`N_PHASE] <= phase_reactive_reversed_flag;
        end
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // reversal flags
  // ----------------------------------------------------------------------
  // write one to clear on the status word
  always_comb begin
    clr_act = '0;
    clr_react = '0;
    if (do_write && reg_hit(wr_addr, `STAT_ZERO_IDX)) begin
      if (wr_strb[0]) begin
        clr_act[1:0] = wr_data[`ST_ACT_REV_LSB+:2];
      end
      if (wr_strb[1]) begin
        clr_act[2] = wr_data[`ST_ACT_REV_LSB+2];
        clr_react = wr_data[`ST_REACT_REV_LSB+:`N_PHASE];
      end
    end
  end

  logic [`N_PHASE-1:0] act_neg_prev;
  logic [`N_PHASE-1:0] react_neg_prev;
  logic sign_seen;
  logic [`N_PHASE-1:0] act_neg_now;
  logic [`N_PHASE-1:0] react_neg_now;
  logic [`N_PHASE-1:0] set_act;
  logic [`N_PHASE-1:0] set_react;

  genvar ph;
  generate
    for (ph = 0; ph < `N_PHASE; ph++) begin : g_phase
      // source bit picks total (0) or fundamental (1) term of the phase
      assign act_neg_now[ph] =
        act_pwr_i[2*ph + active_reversal_source_sel][`PWR_W-1];
      assign react_neg_now[ph] =
        react_pwr_i[2*ph + reactive_reversal_source_sel][`PWR_W-1];
      assign set_act[ph] = pwr_upd_i && sign_seen &&
                           (act_neg_now[ph] != act_neg_prev[ph]);
      assign set_react[ph] = pwr_upd_i && sign_seen &&
                             (react_neg_now[ph] != react_neg_prev[ph]);
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      act_neg_prev <= '0;
      react_neg_prev <= '0;
      sign_seen <= 1'b0;
    end else if (ce_i && pwr_upd_i) begin
      act_neg_prev <= act_neg_now;
      react_neg_prev <= react_neg_now;
      sign_seen <= 1'b1;
    end
  end

  // a new sign change beats a clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_active_reversed_flag <= '0;
      phase_reactive_reversed_flag <= '0;
      active_reversed_o <= '0;
      reactive_reversed_o <= '0;
    end else if (ce_i) begin
      phase_active_reversed_flag <= (phase_active_reversed_flag & ~clr_act) | set_act;
      phase_reactive_reversed_flag <=
        (phase_reactive_reversed_flag & ~clr_react) | set_react;
      active_reversed_o <= phase_active_reversed_flag;
      reactive_reversed_o <= phase_reactive_reversed_flag;
    end
  end

  // ----------------------------------------------------------------------
  // term shaping
  // ----------------------------------------------------------------------
  power_t act_e [`N_TERM];
  power_t act_p [`N_TERM];
  power_t react_e [`N_TERM];
  power_t react_p [`N_TERM];

  genvar t;
  generate
    for (t = 0; t < `N_TERM; t++) begin : g_term
      power_term_cond u_act (
        .react_i(1'b0),
        .mode_i(active_accum_mode),
        .act_neg_i(1'b0),
        .pwr_i(act_pwr_i[t]),
        .energy_o(act_e[t]),
        .pulse_o(act_p[t])
      );
      // reactive term pairs with the active term of the same phase and kind
      power_term_cond u_react (
        .react_i(1'b1),
        .mode_i(reactive_accum_mode),
        .act_neg_i(act_pwr_i[t][`PWR_W-1]),
        .pwr_i(react_pwr_i[t]),
        .energy_o(react_e[t]),
        .pulse_o(react_p[t])
      );
    end
  endgenerate

  // modes are sampled only at an update; nothing downstream is cleared
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      terms_valid_o <= 1'b0;
      act_energy_o <= '0;
      act_pulse_o <= '0;
      react_energy_o <= '0;
      react_pulse_o <= '0;
    end else if (ce_i) begin
      terms_valid_o <= pwr_upd_i;
      if (pwr_upd_i) begin
        for (int i = 0; i < `N_TERM; i++) begin
          act_energy_o[i] <= act_e[i];
          act_pulse_o[i] <= act_p[i];
          react_energy_o[i] <= react_e[i];
          react_pulse_o[i] <= react_p[i];
        end
      end
    end
  end

endmodule : energy_accum_mode_config

// File: core/power_term_cond.sv
// One power term shaped for the energy register path and the pulse path.
// Assumes the caller registers the outputs; purely combinational.
`timescale 1ns/1ps
`include "accum_consts.svh"

module power_term_cond import accum_pkg::*; (
  // selection
  input wire logic react_i,
  input wire logic [1:0] mode_i,
  input wire logic act_neg_i,
  // term
  input wire power_t pwr_i,
  output power_t energy_o,
  output power_t pulse_o
);

  power_t mag;
  power_t inv;

  // note: the most negative code wraps when negated
  always_comb begin
    inv = -pwr_i;
    mag = pwr_i[`PWR_W-1] ? inv : pwr_i;
    energy_o = pwr_i;
    pulse_o = pwr_i;
    if (!react_i) begin
      unique case (act_mode_t'(mode_i))
        ACT_SIGNED, ACT_RSVD: begin
          energy_o = pwr_i;
          pulse_o = pwr_i;
        end
        ACT_POS_ONLY: begin
          energy_o = pwr_i[`PWR_W-1] ? '0 : pwr_i;
          pulse_o = pwr_i;
        end
        ACT_ABS: begin
          energy_o = mag;
          pulse_o = mag;
        end
      endcase
    end else begin
      unique case (react_mode_t'(mode_i))
        REACT_SIGNED, REACT_RSVD: begin
          energy_o = pwr_i;
          pulse_o = pwr_i;
        end
        REACT_BY_ACT: begin
          energy_o = act_neg_i ? inv : pwr_i;
          pulse_o = act_neg_i ? inv : pwr_i;
        end
        REACT_ABS: begin
          energy_o = mag;
          pulse_o = mag;
        end
      endcase
    end
  end

endmodule : power_term_cond

// File: sim/energy_accum_mode_config_sva.sv
// Checker for the mode configuration bank, attached to its top module by bind.
// Assumes bus traffic and power updates arrive while ce_i is high.
`timescale 1ns/1ps
`include "accum_consts.svh"

module energy_accum_mode_config_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // bus
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [`DATA_W-1:0] s_axi_rdata_o,
  // terms
  input wire logic pwr_upd_i,
  input wire logic [`N_TERM-1:0][`PWR_W-1:0] act_pwr_i,
  input wire logic [`N_TERM-1:0][`PWR_W-1:0] react_pwr_i,
  input wire logic terms_valid_o,
  input wire logic [`N_TERM-1:0][`PWR_W-1:0] act_energy_o,
  input wire logic [`N_TERM-1:0][`PWR_W-1:0] act_pulse_o,
  input wire logic [`N_TERM-1:0][`PWR_W-1:0] react_energy_o,
  input wire logic [`N_TERM-1:0][`PWR_W-1:0] react_pulse_o,
  // status
  input wire logic [`N_PHASE-1:0] active_reversed_o,
  input wire logic [`N_PHASE-1:0] reactive_reversed_o,
  input wire logic [`N_PHASE-1:0] peak_phase_include_o
);
  typedef logic [`N_TERM-1:0][`PWR_W-1:0] terms_t;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // pulse is the term or its magnitude; energy is the pulse or a clipped negative
  function automatic logic act_ok(terms_t e, terms_t p, terms_t x);
    act_ok = 1'h1;
    for (int t = 0; t < `N_TERM; t++) begin
      if (!(p[t] == x[t] || (p[t] == -x[t] && x[t][23]))) act_ok = 1'h0;
      if (!(e[t] == p[t] || (e[t] == 24'h0 && p[t][23]))) act_ok = 1'h0;
    end
  endfunction : act_ok

  function automatic logic react_ok(terms_t e, terms_t p, terms_t x);
    react_ok = (e == p);
    for (int t = 0; t < `N_TERM; t++) begin
      if (!(p[t] == x[t] || p[t] == -x[t])) react_ok = 1'h0;
    end
  endfunction : react_ok

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  property p_terms_valid;
    pwr_upd_i && ce_i |=> terms_valid_o;
  endproperty
  a_terms_valid: assert property (p_terms_valid)
    else $error("no terms_valid_o after update");
  property p_act_path;
    pwr_upd_i && ce_i |=> act_ok(act_energy_o, act_pulse_o, $past(act_pwr_i));
  endproperty
  a_act_path: assert property (p_act_path)
    else $error("active term shaping wrong");
  property p_react_path;
    pwr_upd_i && ce_i |=> react_ok(react_energy_o, react_pulse_o, $past(react_pwr_i));
  endproperty
  a_react_path: assert property (p_react_path)
    else $error("reactive term shaping wrong");
  property p_write_answer;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o && ce_i
      |=> ##1 s_axi_bvalid_o;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response late");
  property p_read_answer;
    s_axi_arvalid_i && s_axi_arready_o && ce_i |=> s_axi_rvalid_o;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read data late");
  property p_bresp_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response dropped");
  property p_rdata_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data dropped");
  property p_slot_free;
    $fell(s_axi_bvalid_o) |-> s_axi_awready_o && s_axi_wready_o;
  endproperty
  a_slot_free: assert property (p_slot_free)
    else $error("write slot not freed");
  property p_act_flag;
    |(active_reversed_o & ~$past(active_reversed_o)) |-> $past(pwr_upd_i, 2);
  endproperty
  a_act_flag: assert property (p_act_flag)
    else $error("active flag rose without update");
  property p_react_flag;
    |(reactive_reversed_o & ~$past(reactive_reversed_o)) |-> $past(pwr_upd_i, 2);
  endproperty
  a_react_flag: assert property (p_react_flag)
    else $error("reactive flag rose without update");
  property p_peak_reset;
    $rose(rst_b_i) |-> peak_phase_include_o == 3'h7 && !s_axi_bvalid_o;
  endproperty
  a_peak_reset: assert property (p_peak_reset)
    else $error("peak phases not all included after reset");

  c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
  c_flag: cover property ($rose(active_reversed_o[0]));
  c_update: cover property (terms_valid_o);
endmodule : energy_accum_mode_config_sva

// ----------------------------------------------------------------------
// bind
// ----------------------------------------------------------------------
bind energy_accum_mode_config energy_accum_mode_config_sva energy_accum_mode_config_sva_inst (
  .clk_i, .rst_b_i, .ce_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .pwr_upd_i,
  .act_pwr_i, .react_pwr_i, .terms_valid_o, .act_energy_o, .act_pulse_o, .react_energy_o,
  .react_pulse_o, .active_reversed_o, .reactive_reversed_o, .peak_phase_include_o
);

// File: sim/energy_accum_mode_config_tb.sv
// Bench for the mode configuration bank: bus access, term shaping, reversal flags.
// Assumes the package and constants header are compiled before it.
`timescale 1ns/1ps
`include "accum_consts.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end

module energy_accum_mode_config_tb import accum_pkg::*; ;
  typedef logic [`N_TERM-1:0][`PWR_W-1:0] terms_t;
  localparam logic [17:0] meas_a = {`MEAS_MODE_IDX, 2'h0};
  localparam logic [17:0] acc_a = {`ACC_MODE_IDX, 2'h0};
  localparam logic [17:0] stat_a = {`STAT_ZERO_IDX, 2'h0};
  localparam logic [17:0] bad_a = 18'h3FFF0;
  localparam logic [1:0] okay = `RESP_OKAY;
  localparam logic [1:0] slverr = `RESP_SLVERR;
  logic clk_i = 1'h0;
  logic rst_b_i = 1'h0;
  logic ce_i = 1'h1;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic upd = 1'h0;
  logic [17:0] awaddr = 18'h0;
  logic [17:0] araddr = 18'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  terms_t act_in = '0;
  terms_t react_in = '0;
  logic awready, wready, bvalid, arready, rvalid, tv;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  terms_t ae, ap, re, rp;
  logic [2:0] arev, rrev, peak;
  int errors = 0;
  int comparisons = 0;

  always #20 clk_i = ~clk_i;

  energy_accum_mode_config energy_accum_mode_config_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .pwr_upd_i(upd),
    .act_pwr_i(act_in), .react_pwr_i(react_in), .terms_valid_o(tv),
    .act_energy_o(ae), .act_pulse_o(ap), .react_energy_o(re), .react_pulse_o(rp),
    .active_reversed_o(arev), .reactive_reversed_o(rrev), .peak_phase_include_o(peak)
  );

  // ----------------------------------------------------------------------
  // bus and term drivers
  // ----------------------------------------------------------------------
  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_i);
    awvalid <= 1'h1;
    awaddr <= a;
    wvalid <= 1'h1;
    wdata <= d;
    bready <= 1'h1;
    do begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    `CHK("bresp", er, bresp)
  endtask : wr

  task automatic rd(input logic [17:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk_i);
    arvalid <= 1'h1;
    araddr <= a;
    rready <= 1'h1;
    do begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    `CHK("rdata", e, rdata)
    `CHK("rresp", er, rresp)
  endtask : rd

  // distinct magnitude per term, negative where neg is set
  function automatic terms_t mk(input logic [5:0] neg);
    for (int t = 0; t < 6; t++) mk[t] = neg[t] ? -24'(t * 16 + 256) : 24'(t * 16 + 256);
  endfunction : mk

  task automatic send(input terms_t a, input terms_t r);
    @(posedge clk_i);
    upd <= 1'h1;
    act_in <= a;
    react_in <= r;
    @(posedge clk_i);
    upd <= 1'h0;
    @(negedge clk_i);
  endtask : send

  task automatic chk_terms(input logic [1:0] am, input logic [1:0] rm);
    logic signed [23:0] x, y, ep, ee, ry;
    for (int t = 0; t < 6; t++) begin
      x = act_in[t];
      y = react_in[t];
      ep = (am == 2'h3 && x < 0) ? -x : x;
      ee = (am == 2'h1 && x < 0) ? 24'h0 : ep;
      ry = ((rm == 2'h3 && y < 0) || (rm == 2'h2 && x < 0)) ? -y : y;
      `CHK("act_pulse", ep, ap[t])
      `CHK("act_energy", ee, ae[t])
      `CHK("react_pulse", ry, rp[t])
      `CHK("react_energy", ry, re[t])
    end
  endtask : chk_terms

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  task automatic t_reset;
    rd(meas_a, 32'h1C, okay);
    rd(acc_a, 32'h0, okay);
    `CHK("peak", 3'h7, peak)
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs;
    wr(meas_a, 32'hF4, okay);
    rd(meas_a, 32'h14, okay);
    `CHK("peak", 3'h5, peak)
    wr(bad_a, 32'hFF, slverr);
    rd(bad_a, 32'h0, slverr);
    wr(meas_a, 32'h1C, okay);
    @(posedge clk_i);
    ce_i <= 1'h0;
    upd <= 1'h1;
    @(posedge clk_i);
    ce_i <= 1'h1;
    upd <= 1'h0;
    @(negedge clk_i);
    `CHK("frozen", 1'h0, tv)
    $display("test regs done");
  endtask : t_regs

  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      wr(acc_a, 32'(m), okay);
      send(mk(6'h2A), mk(6'h07));
      `CHK("valid", 1'h1, tv)
      chk_terms(2'(m), 2'h0);
      wr(acc_a, 32'(m * 4 + 1), okay);
      send(mk(6'h2A), mk(6'h07));
      chk_terms(2'h1, 2'(m));
    end
    $display("test modes done");
  endtask : t_modes

  task automatic flags(input logic [2:0] ea, input logic [2:0] er);
    @(negedge clk_i);
    `CHK("act_rev", ea, arev)
    `CHK("react_rev", er, rrev)
  endtask : flags

  task automatic t_flags;
    send(mk(6'h00), mk(6'h00));
    wr(stat_a, 32'h1DC0, okay);
    rd(stat_a, 32'h0, okay);
    send(mk(6'h01), mk(6'h10));
    flags(3'h1, 3'h4);
    rd(stat_a, 32'h1040, okay);
    wr(stat_a, 32'h1DC0, okay);
    wr(meas_a, 32'h1F, okay);
    send(mk(6'h02), mk(6'h20));
    flags(3'h0, 3'h0);
    send(mk(6'h00), mk(6'h00));
    flags(3'h1, 3'h4);
    wr(meas_a, 32'h1C, okay);
    $display("test flags done");
  endtask : t_flags

  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'h1;
    t_reset;
    t_regs;
    t_modes;
    t_flags;
    wrap_up;
  end

  initial begin
    #400000;
    errors++;
    $display("ERROR watchdog expected finish seen hang");
    wrap_up;
  end
endmodule : energy_accum_mode_config_tb
